// >>> rtl/dma_serial_tx.sv
// Purpose: serial transmitter modelled on chained transfer channels and a bit timer
// Assumes: inputs synchronous to clk; message buffer loaded before start
// Notes:   parallel word is registered from the same next slot values, so both views always agree
//
// Functional notes
// [R1] each character is ten one-byte moves of single frame bits onto the pin
// [R2] bit timer fires at 9600 Hz; one overflow gives exactly one bit
// [R3] frame is start bit, eight mirrored data bits, then stop bit
// [R4] per-pin slots and parallel word show the same pin state both ways
// [R5] bit channel major-loop end links to buffer channel for next character
// [R6] buffer channel moves one message byte into eight data slots, advancing
// [R7] continuous mode keeps bit channel enabled, repeating message forever
// [R8] software starts fixed-length burst by activating buffer channel
// [R9] fixed mode sends exactly the message array size in characters; code sends msg_len characters instead
// [R10] variable mode compare channel copies each outgoing byte to comparator
// [R11] comparator match requests control channel, which stops the bit timer
// [R12] the variable-length terminator is the zero byte
// [R13] variable mode starts by control channel enabling timer; stops on terminator
// [R14] scatter-gather: after 12 characters a user descriptor writes timer stop
// [R15] after stop descriptor the original descriptor is reloaded for next message
// [R16] software aligns user descriptors on 32-byte boundaries
// [R17] with minor and major links both due, only the major link is made
// [R18] stopped timer leaves the pin at stop-bit level, idling high
`timescale 1ns/1ps
module dma_serial_tx
  import dma_serial_tx_pkg::*;
#(
  parameter int unsigned BIT_CYCLES_P = BIT_CYCLES,
  parameter int unsigned MSG_DEPTH_P  = MSG_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] msg_len,
  input  wire logic       msg_wr,
  input  wire logic [7:0] msg_wr_addr,
  input  wire logic [7:0] msg_wr_data,
  input  wire logic       start,
  input  wire logic       par_wr,
  input  wire logic [7:0] par_wr_data,
  output logic            tx_pin,
  output logic            busy,
  output logic [7:0]      port_parallel_output_word,
  output logic [7:0]      comparator_value,
  output logic            timer_running
);
  logic [7:0]  message_buffer [MSG_DEPTH_P];
  tx_state_t   st_r, st_nxt;
  logic [7:0]  slot_r [FRAME_MOVES];
  logic [7:0]  slot_nxt [FRAME_MOVES];
  logic [15:0] tmr_r, tmr_nxt;
  logic        run_r, run_nxt;
  logic [3:0]  move_r, move_nxt;
  logic [7:0]  rd_r, rd_nxt;
  logic [7:0]  sent_r, sent_nxt;
  logic [7:0]  cmp_r, cmp_nxt;
  logic        pin_r, pin_nxt;
  logic        busy_r, busy_nxt;
  logic        tick;
  logic        f_in_valid, f_in_ready, f_out_valid, f_pop;
  logic [7:0]  f_out;
  logic        f_flush;
  localparam int unsigned MSG_AW = $clog2(MSG_DEPTH_P);

  // a start refused while busy must not throw away bytes already fetched
  assign f_flush = start && (st_r == ST_IDLE);

  // buffer channel fetches ahead into the fifo; stalls when fifo is full
  assign f_in_valid = busy_r && (rd_r < msg_len) && (mode != MODE_CONT || msg_len != 8'h00);
  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_data   (message_buffer[rd_r[MSG_AW-1:0]]),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .out_data  (f_out),
    .out_valid (f_out_valid),
    .out_ready (f_pop),
    .flush     (f_flush)
  );

  assign tick  = run_r && (tmr_r == 16'((BIT_CYCLES_P - 1) & 16'hFFFF)); // [R2]
  assign f_pop = (st_r == ST_LOAD) && f_out_valid;

  always_ff @(posedge clk) begin
    if (msg_wr) begin
      message_buffer[msg_wr_addr[MSG_AW-1:0]] <= msg_wr_data;
    end
  end

  always_comb begin
    st_nxt   = st_r;
    tmr_nxt  = run_r ? (tick ? 16'h0000 : tmr_r + 16'h0001) : 16'h0000;
    run_nxt  = run_r;
    move_nxt = move_r;
    rd_nxt   = rd_r;
    sent_nxt = sent_r;
    cmp_nxt  = cmp_r;
    pin_nxt  = pin_r;
    busy_nxt = busy_r;
    for (int i = 0; i < FRAME_MOVES; i++) begin
      slot_nxt[i] = slot_r[i];
    end
    slot_nxt[0]             = START_BIT_SLOT; // [R3]
    slot_nxt[FRAME_MOVES-1] = STOP_BIT_SLOT; // [R3]
    if (par_wr) begin
      for (int i = 0; i < DATA_BITS; i++) begin
        slot_nxt[i+1] = {7'h00, par_wr_data[i]}; // [R4]
      end
    end
    if (f_in_valid && f_in_ready) begin
      rd_nxt = rd_r + 8'h01;
      if (mode == MODE_CONT && rd_r + 8'h01 >= msg_len) begin
        rd_nxt = 8'h00; // [R7]
      end
    end
    case (st_r)
      ST_IDLE: begin
        pin_nxt = 1'b1; // [R18]
        if (start) begin
          // fixed/sg: software activates buffer channel; var: control channel
          busy_nxt = 1'b1; // [R8] [R13]
          run_nxt  = 1'b1; // [R13]
          rd_nxt   = 8'h00;
          sent_nxt = 8'h00;
          st_nxt   = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (f_out_valid) begin
          for (int i = 0; i < DATA_BITS; i++) begin
            slot_nxt[i+1] = {7'h00, f_out[i]}; // [R6]
          end
          cmp_nxt  = f_out; // [R10]
          sent_nxt = sent_r + 8'h01;
          move_nxt = 4'h0;
          if (mode == MODE_VAR && f_out == TERMINATOR) begin
            run_nxt  = 1'b0; // [R11] [R12]
            busy_nxt = 1'b0;
            st_nxt   = ST_IDLE;
          end else begin
            st_nxt = ST_BITS;
          end
        end else if (mode != MODE_CONT && rd_r >= msg_len) begin
          run_nxt  = 1'b0;
          busy_nxt = 1'b0;
          st_nxt   = ST_IDLE;
        end
      end
      ST_BITS: begin
        if (tick) begin
          pin_nxt  = slot_r[move_r][0]; // [R1]
          move_nxt = move_r + 4'h1;
          if (move_r == 4'(FRAME_MOVES - 1)) begin
            // major loop end: only the major link to the buffer channel
            move_nxt = 4'h0; // [R17]
            if (mode == MODE_SG && sent_r == 8'(SG_MAJOR_COUNT)) begin
              st_nxt = ST_STOPDSC; // [R14]
            end else if (mode == MODE_FIXED && sent_r >= msg_len) begin
              run_nxt  = 1'b0; // [R9]
              busy_nxt = 1'b0;
              st_nxt   = ST_IDLE;
            end else begin
              st_nxt = ST_LOAD; // [R5] [R7]
            end
          end
        end
      end
      ST_STOPDSC: begin
        run_nxt = 1'b0; // [R14]
        st_nxt  = ST_RELOAD;
      end
      ST_RELOAD: begin
        rd_nxt   = 8'h00; // [R15]
        sent_nxt = 8'h00;
        busy_nxt = 1'b0;
        st_nxt   = ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r   <= ST_IDLE;
      tmr_r  <= 16'h0000;
      run_r  <= 1'b0;
      move_r <= 4'h0;
      rd_r   <= 8'h00;
      sent_r <= 8'h00;
      cmp_r  <= 8'hFF;
      pin_r  <= 1'b1;
      busy_r <= 1'b0;
      for (int i = 0; i < FRAME_MOVES; i++) begin
        slot_r[i] <= 8'h01;
      end
    end else begin
      st_r   <= st_nxt;
      tmr_r  <= tmr_nxt;
      run_r  <= run_nxt;
      move_r <= move_nxt;
      rd_r   <= rd_nxt;
      sent_r <= sent_nxt;
      cmp_r  <= cmp_nxt;
      pin_r  <= pin_nxt;
      busy_r <= busy_nxt;
      for (int i = 0; i < FRAME_MOVES; i++) begin
        slot_r[i] <= slot_nxt[i];
      end
    end
  end

  // parallel word registered straight from the shared slots
  logic [7:0] par_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      par_r <= 8'hFF;
    end else begin
      for (int i = 0; i < DATA_BITS; i++) begin
        par_r[i] <= slot_nxt[i+1][0]; // [R4]
      end
    end
  end

  assign tx_pin                    = pin_r;
  assign busy                      = busy_r;
  assign port_parallel_output_word = par_r;
  assign comparator_value          = cmp_r;
  assign timer_running             = run_r;
endmodule

// >>> rtl/dma_serial_tx_pkg.sv
// Purpose: shared constants for the chained-transfer serial transmitter
// Assumes: 40 MHz system clock
// Notes:   frame is start bit, eight data bits, stop bit
package dma_serial_tx_pkg;
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned BIT_RATE_HZ     = 9600;
  localparam int unsigned BIT_CYCLES      = CLK_HZ / BIT_RATE_HZ;
  localparam int unsigned FRAME_MOVES     = 10;
  localparam int unsigned DATA_BITS       = 8;
  localparam int unsigned SG_MAJOR_COUNT  = 12;
  localparam int unsigned DESC_ALIGN_BYTES = 32;
  localparam logic [7:0]  TERMINATOR      = 8'h00;
  localparam logic [7:0]  START_BIT_SLOT  = 8'h00;
  localparam logic [7:0]  STOP_BIT_SLOT   = 8'h01;
  localparam logic [1:0]  MODE_CONT       = 2'h0;
  localparam logic [1:0]  MODE_FIXED      = 2'h1;
  localparam logic [1:0]  MODE_VAR        = 2'h2;
  localparam logic [1:0]  MODE_SG         = 2'h3;
  localparam int unsigned FIFO_DEPTH      = 8;
  localparam int unsigned MSG_DEPTH       = 64;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_LOAD    = 5'b00010,
    ST_BITS    = 5'b00100,
    ST_STOPDSC = 5'b01000,
    ST_RELOAD  = 5'b10000
  } tx_state_t;
endpackage

// >>> rtl/byte_fifo.sv
// Purpose: small valid/ready FIFO in the message data path
// Assumes: power-of-two depth
// Notes:   full and empty come from an occupancy counter
`timescale 1ns/1ps
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  input  wire logic             flush
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_nxt  = wr_r + AW'(push);
    rd_nxt  = rd_r + AW'(pop);
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      wr_nxt  = '0;
      rd_nxt  = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end
endmodule

// >>> verif/serial_rx_model.sv
// Purpose: remote serial receiver decoding the transmit line
// Assumes: bit period of BIT clock cycles, line idles high
// Notes:   samples mid-bit; passive, so it cannot be kinder than a real receiver
`timescale 1ns/1ps
module serial_rx_model #(
  parameter int unsigned BIT = 8
) (
  input wire logic clk,
  input wire logic line
);
  logic [7:0] q [$];
  logic [7:0] b;
  int         ferr = 0;
  int         i;
  always begin
    @(negedge line);
    repeat (BIT / 2) @(posedge clk);
    if (line !== 1'b0) ferr++;
    for (i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      b[i] = line;
    end
    repeat (BIT) @(posedge clk);
    if (line !== 1'b1) ferr++;
    q.push_back(b);
  end
endmodule

// >>> verif/dma_serial_tx_props.sv
// Purpose: port-level timing checks of the serial transmitter
// Assumes: one clock domain, async active-low reset
// Notes:   bit hold measured by a saturating gap counter
`timescale 1ns/1ps
module dma_serial_tx_props
  import dma_serial_tx_pkg::*;
#(
  parameter int unsigned BIT_CYCLES_P = BIT_CYCLES
) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic [1:0] mode,
  input wire logic [7:0] msg_len,
  input wire logic       msg_wr,
  input wire logic [7:0] msg_wr_addr,
  input wire logic [7:0] msg_wr_data,
  input wire logic       start,
  input wire logic       par_wr,
  input wire logic [7:0] par_wr_data,
  input wire logic       tx_pin,
  input wire logic       busy,
  input wire logic [7:0] port_parallel_output_word,
  input wire logic [7:0] comparator_value,
  input wire logic       timer_running
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic        pin_r;
  logic [15:0] gap_r;
  logic [15:0] gap_nxt;
  always_comb begin
    gap_nxt = (gap_r == 16'hFFFF) ? gap_r : gap_r + 16'h1;
    if (tx_pin != pin_r) gap_nxt = 16'h0;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_r <= 1'b1;
      gap_r <= 16'hFFFF;
    end else begin
      pin_r <= tx_pin;
      gap_r <= gap_nxt;
    end
  end
  sequence s_go; start && !busy; endsequence
  sequence s_up; busy && timer_running; endsequence
  property p_start; s_go |=> s_up; endproperty
  property p_hold; $changed(tx_pin) |-> gap_r >= 16'(BIT_CYCLES_P - 1); endproperty
  property p_idle; !busy && !timer_running |-> tx_pin; endproperty
  property p_run; timer_running |-> busy; endproperty
  property p_end; $fell(timer_running) |-> ##[0:3] !busy; endproperty
  property p_cont; mode == MODE_CONT && busy |=> busy; endproperty
  property p_cmp; $changed(comparator_value) |-> $past(busy); endproperty
  property p_term;
    mode == MODE_VAR && $changed(comparator_value) && comparator_value == TERMINATOR
      |-> ##[0:3] !timer_running;
  endproperty
  property p_word;
    !busy && !$past(busy) && $past(par_wr) |-> port_parallel_output_word == $past(par_wr_data);
  endproperty
  a_start: assert property (p_start) else $error("no start response");
  a_hold: assert property (p_hold) else $error("bit held too short");
  a_idle: assert property (p_idle) else $error("line not idle high");
  a_run: assert property (p_run) else $error("timer runs while idle");
  a_end: assert property (p_end) else $error("busy after stop");
  a_cont: assert property (p_cont) else $error("continuous run ended");
  a_cmp: assert property (p_cmp) else $error("compare load while idle");
  a_term: assert property (p_term) else $error("terminator did not stop");
  a_word: assert property (p_word) else $error("parallel write lost");
endmodule
bind dma_serial_tx dma_serial_tx_props #(.BIT_CYCLES_P(BIT_CYCLES_P)) u_props (
  .clk(clk), .arst_n(arst_n), .mode(mode), .msg_len(msg_len), .msg_wr(msg_wr),
  .msg_wr_addr(msg_wr_addr), .msg_wr_data(msg_wr_data), .start(start), .par_wr(par_wr),
  .par_wr_data(par_wr_data), .tx_pin(tx_pin), .busy(busy), .timer_running(timer_running),
  .port_parallel_output_word(port_parallel_output_word), .comparator_value(comparator_value));

// >>> verif/testbench.sv
// Purpose: self-checking bench for the serial transmitter
// Assumes: bit period shortened to 8 cycles
// Notes:   inputs change on falling edges; receiver model judges frames
`timescale 1ns/1ps
module testbench
  import dma_serial_tx_pkg::*;
;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [7:0] msg_len = 8'h00;
  logic       msg_wr = 1'b0;
  logic [7:0] msg_wr_addr = 8'h00;
  logic [7:0] msg_wr_data = 8'h00;
  logic       start = 1'b0;
  logic       par_wr = 1'b0;
  logic [7:0] par_wr_data = 8'h00;
  logic       tx_pin, busy, timer_running;
  logic [7:0] word, cmp;
  logic [7:0] msg [16];
  int         fails = 0;
  int         checked = 0;
  int         cyc = 0;
  dma_serial_tx #(.BIT_CYCLES_P(8)) uut (.clk(clk), .arst_n(arst_n), .mode(mode),
    .msg_len(msg_len), .msg_wr(msg_wr), .msg_wr_addr(msg_wr_addr), .msg_wr_data(msg_wr_data),
    .start(start), .par_wr(par_wr), .par_wr_data(par_wr_data), .tx_pin(tx_pin), .busy(busy),
    .port_parallel_output_word(word), .comparator_value(cmp), .timer_running(timer_running));
  serial_rx_model #(.BIT(8)) rx (.clk(clk), .line(tx_pin));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    // ceiling well above the roughly 3000 cycles the scenarios need
    if (cyc == 20000) begin
      fails++;
      give_verdict;
    end
  end
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    msg_wr = 1'b1;
    msg_wr_addr = a;
    msg_wr_data = d;
    @(negedge clk);
    msg_wr = 1'b0;
  endtask
  task automatic pulse;
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask
  task automatic go(input logic [1:0] m, input logic [7:0] n);
    mode = m;
    msg_len = n;
    rx.q.delete();
    pulse();
    chk(16'(busy), 16'h1);
  endtask
  task automatic finish_run(input int n);
    for (int k = 0; k < 4000 && busy !== 1'b0; k++) @(negedge clk);
    repeat (24) @(negedge clk);
    chk(16'(busy), 16'h0);
    chk(16'(rx.q.size()), 16'(n));
    for (int k = 0; k < n; k++) chk(16'(rx.q[k]), 16'(msg[k]));
    chk(16'(rx.ferr), 16'h0);
  endtask
  task automatic t_fixed;
    go(MODE_FIXED, 8'h03);
    repeat (40) @(negedge clk);
    // a start while busy is refused and must not disturb the burst
    pulse();
    finish_run(3);
    chk(16'(word), 16'(msg[2]));
  endtask
  task automatic t_var;
    put(8'h03, TERMINATOR);
    go(MODE_VAR, 8'h10);
    finish_run(3);
    chk(16'(cmp), 16'(TERMINATOR));
    chk(16'(timer_running), 16'h0);
    put(8'h03, msg[3]);
  endtask
  task automatic t_sg;
    // stop and reload descriptors sit inside the block, aligned by construction
    go(MODE_SG, 8'h10);
    finish_run(12);
    go(MODE_SG, 8'h10);
    finish_run(12);
  endtask
  task automatic t_par;
    @(negedge clk);
    par_wr = 1'b1;
    par_wr_data = 8'h3C;
    @(negedge clk);
    par_wr = 1'b0;
    chk(16'(word), 16'h3C);
  endtask
  task automatic t_cont;
    go(MODE_CONT, 8'h02);
    for (int k = 0; k < 1000 && rx.q.size() < 5; k++) @(negedge clk);
    chk(16'(busy), 16'h1);
    chk(16'(rx.q[4]), 16'(msg[0]));
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(tx_pin), 16'h1);
    arst_n = 1'b1;
    // after a mid-run reset nothing restarts without a fresh start pulse
    repeat (2) @(negedge clk);
    chk(16'(busy), 16'h0);
    chk(16'(tx_pin), 16'h1);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    for (int i = 0; i < 16; i++) begin
      msg[i] = 8'(i * 37 + 1);
      put(8'(i), msg[i]);
    end
    t_fixed();
    t_var();
    t_sg();
    t_par();
    t_cont();
    give_verdict;
  end
endmodule
